// file: gpio_pin_control_22.sv
// Twenty-two pin general purpose port with Avalon-MM register access
//
// Contract
// - Each pin has an input-enable bit; 0 after reset disables input, 1 enables.
// - Strap low at reset keeps every pin an output; input enables ignored.
// - Each pin has a pull-down control bit; 1 active, 0 inactive.
// - Pull-down registers reset to FFFF and 003F, all pull-downs active.
// - Pull-down pins 0-15 on low bits 15-0, pins 16-21 on high bits 5-0.
// - For an output pin, writing its status bit drives the pin to that value.
// - For an input pin, reading its status bit returns the pin level.
// - Status pins 0-15 on low bits 15-0, 16-21 on high 5-0; reset zero.
// - Strap high: direction bit 0 selects input, 1 output; strap low ignores it.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "gpio_consts.svh"
module gpio_pin_control_22
  import gpio_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        direction_strap,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [21:0] pin_in,
  output logic      [21:0] pin_out,
  output logic      [21:0] pin_oe_n,
  output logic      [21:0] pin_pulldown_en
);

  // ==========================================================
  // Helper functions
  // Merge a 16-bit write into one half of a 22-bit field, honouring byte enables
  function automatic logic [21:0] merge_half(input logic [21:0] cur,
                                             input logic        high,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  be);
    logic [15:0] half;
    logic [21:0] res;
    half = high ? {10'h000, cur[21:16]} : cur[15:0];
    if (be[0]) half[7:0] = wdata[7:0];
    if (be[1]) half[15:8] = wdata[15:8];
    res = cur;
    if (high) res[21:16] = half[5:0];
    else res[15:0] = half;
    return res;
  endfunction

  // Select one half of a 22-bit field as a 32-bit read word, upper bits zero
  function automatic logic [31:0] read_half(input logic [21:0] v, input logic high);
    return high ? {26'h0000000, v[21:16]} : {16'h0000, v[15:0]};
  endfunction

  // ==========================================================
  // Storage
  bus_req_t    req;
  bus_state_t  bus_q;
  logic [21:0] dir_q;
  logic [21:0] inen_q;
  logic [21:0] pull_q;
  logic [21:0] level_q;
  logic        strap_q;
  logic        strap_taken_q;
  logic [21:0] is_output;
  logic [21:0] input_allowed;
  logic [21:0] sampled_q;
  logic [21:0] status_view;
  logic [31:0] read_word;
  logic        addr_hit;
  pin_drive_t  drive_d;
  pin_drive_t  drive_q;

  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 writedata: avs_writedata, byteenable: avs_byteenable};

  // ==========================================================
  // Strap capture
  // Caught on the first enabled edge after release; until then no pad is driven,
  // so a pin strapped as an input never fights the board for a cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_q       <= 1'b0;
      strap_taken_q <= 1'b0;
    end else if (clk_en && !strap_taken_q) begin
      strap_q       <= direction_strap;
      strap_taken_q <= 1'b1;
    end
  end

  // ==========================================================
  // Direction and input gating
  always_comb begin
    is_output     = strap_taken_q ? (strap_q ? dir_q : 22'h3FFFFF) : 22'h000000;
    input_allowed = ~is_output & inen_q;
  end

  pin_sampler u_sampler (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .clk_en        (clk_en),
    .pin_in        (pin_in),
    .input_allowed (input_allowed),
    .sampled_q     (sampled_q)
  );

  // Output pins read back their written value, input pins their sampled level
  assign status_view = (is_output & level_q) | (~is_output & sampled_q);

  // ==========================================================
  // Bus handshake
  // Writes are answered one cycle after they are seen; reads stall one cycle longer, data registered when seen
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= BUS_IDLE;
    end else if (clk_en) begin
      case (bus_q)
        BUS_IDLE: begin
          if (req.read) bus_q <= BUS_READ;
        end
        BUS_READ: bus_q <= BUS_DONE;
        BUS_DONE: bus_q <= BUS_IDLE;
        default:  bus_q <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= !(bus_q == BUS_READ) && !(req.write && bus_q == BUS_IDLE
                         && avs_waitrequest);
    end
  end

  // ==========================================================
  // Read decode
  always_comb begin
    addr_hit  = 1'b1;
    read_word = 32'h00000000;
    case (req.address)
      `OFS_DIR_LOW:    read_word = read_half(dir_q, 1'b0);
      `OFS_DIR_HIGH:   read_word = read_half(dir_q, 1'b1);
      `OFS_INEN_LOW:   read_word = read_half(inen_q, 1'b0);
      `OFS_INEN_HIGH:  read_word = read_half(inen_q, 1'b1);
      `OFS_PULL_LOW:   read_word = read_half(pull_q, 1'b0);
      `OFS_PULL_HIGH:  read_word = read_half(pull_q, 1'b1);
      `OFS_LEVEL_LOW:  read_word = read_half(status_view, 1'b0);
      `OFS_LEVEL_HIGH: read_word = read_half(status_view, 1'b1);
      default:         addr_hit = 1'b0;
    endcase
  end

  // Unmapped reads return zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (clk_en && bus_q == BUS_IDLE && req.read) begin
      avs_readdata <= addr_hit ? read_word : 32'h00000000;
    end
  end

  // ==========================================================
  // Register writes
  // A write is taken at the edge where waitrequest is sampled low
  logic wr_now;
  assign wr_now = clk_en && req.write && !avs_waitrequest;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= `RST_DIR;
    end else if (wr_now && req.address == `OFS_DIR_LOW) begin
      dir_q <= merge_half(dir_q, 1'b0, req.writedata, req.byteenable);
    end else if (wr_now && req.address == `OFS_DIR_HIGH) begin
      dir_q <= merge_half(dir_q, 1'b1, req.writedata, req.byteenable);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inen_q <= `RST_INEN;
    end else if (wr_now && req.address == `OFS_INEN_LOW) begin
      inen_q <= merge_half(inen_q, 1'b0, req.writedata, req.byteenable);
    end else if (wr_now && req.address == `OFS_INEN_HIGH) begin
      inen_q <= merge_half(inen_q, 1'b1, req.writedata, req.byteenable);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pull_q <= `RST_PULL;
    end else if (wr_now && req.address == `OFS_PULL_LOW) begin
      pull_q <= merge_half(pull_q, 1'b0, req.writedata, req.byteenable);
    end else if (wr_now && req.address == `OFS_PULL_HIGH) begin
      pull_q <= merge_half(pull_q, 1'b1, req.writedata, req.byteenable);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= `RST_LEVEL;
    end else if (wr_now && req.address == `OFS_LEVEL_LOW) begin
      level_q <= merge_half(level_q, 1'b0, req.writedata, req.byteenable);
    end else if (wr_now && req.address == `OFS_LEVEL_HIGH) begin
      level_q <= merge_half(level_q, 1'b1, req.writedata, req.byteenable);
    end
  end

  // ==========================================================
  // Pad drive
  always_comb begin
    drive_d.level   = level_q & is_output;
    drive_d.oe_n    = ~is_output;
    drive_d.pull_en = pull_q;
  end

  pin_driver u_driver (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .drive_d (drive_d),
    .drive_q (drive_q)
  );

  assign pin_out         = drive_q.level;
  assign pin_oe_n        = drive_q.oe_n;
  assign pin_pulldown_en = drive_q.pull_en;

  // ==========================================================
  // Checks
  // Named steps of a bus transfer
  sequence s_write_seen;
    clk_en && req.write && bus_q == BUS_IDLE && avs_waitrequest;
  endsequence

  sequence s_read_seen;
    clk_en && req.read && bus_q == BUS_IDLE;
  endsequence

  sequence s_answer;
    !avs_waitrequest;
  endsequence

  sequence s_data_held;
    $stable(avs_readdata);
  endsequence

  property p_write_answer;
    @(posedge clk_sys) disable iff (!rst_n)
    s_write_seen |=> s_answer;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write not answered in the next cycle");

  // Read data is loaded once and must not move before the master takes it
  property p_read_held;
    @(posedge clk_sys) disable iff (!rst_n)
    s_read_seen |=> ##1 s_data_held;
  endproperty
  a_read_held: assert property (p_read_held)
    else $error("read data changed before it was taken");

  property p_freeze;
    @(posedge clk_sys) disable iff (!rst_n)
    !clk_en |=> ($stable(dir_q) && $stable(inen_q) && $stable(pull_q) && $stable(level_q)
                 && $stable(strap_q) && $stable(sampled_q) && $stable(avs_waitrequest)
                 && $stable(pin_oe_n) && $stable(pin_out));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable was low");

  property p_strap_low_all_out;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && strap_taken_q && !strap_q) |=> (pin_oe_n == 22'h000000 || !$past(clk_en));
  endproperty
  a_strap_low_all_out: assert property (p_strap_low_all_out)
    else $error("strap low but a pin is not driven");

  property p_disabled_input_masked;
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> ((sampled_q & ~$past(input_allowed)) == 22'h000000);
  endproperty
  a_disabled_input_masked: assert property (p_disabled_input_masked)
    else $error("disabled input reached the sampler");

  property p_pull_follows;
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> (pin_pulldown_en == $past(pull_q));
  endproperty
  a_pull_follows: assert property (p_pull_follows)
    else $error("pull-down pad does not follow its control bit");

  property p_out_follows;
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> (pin_out == ($past(level_q) & $past(is_output)));
  endproperty
  a_out_follows: assert property (p_out_follows)
    else $error("output pad does not follow written level");

  property p_dir_select;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && strap_q) |=> (pin_oe_n == ~$past(dir_q));
  endproperty
  a_dir_select: assert property (p_dir_select)
    else $error("direction bit does not select the pad enable");

  property p_readback_out;
    @(posedge clk_sys) disable iff (!rst_n)
    ((status_view & is_output) == (level_q & is_output));
  endproperty
  a_readback_out: assert property (p_readback_out)
    else $error("output pin does not read back written value");

  property p_readback_in;
    @(posedge clk_sys) disable iff (!rst_n)
    ((status_view & ~is_output) == (sampled_q & ~is_output));
  endproperty
  a_readback_in: assert property (p_readback_in)
    else $error("input pin does not read back its level");

  property p_pull_high_bits;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && req.write && !avs_waitrequest && req.address == `OFS_PULL_HIGH
     && req.byteenable[0]) |=> (pull_q[21:16] == $past(req.writedata[5:0]));
  endproperty
  a_pull_high_bits: assert property (p_pull_high_bits)
    else $error("upper pull-down bits misplaced");

  property p_read_answer;
    @(posedge clk_sys) disable iff (!rst_n)
    s_read_seen |=> ##[0:2] s_answer;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered in time");

endmodule

// file: gpio_consts.svh
// Register offsets, field positions, reset values and timing counts of the pin block
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define OFS_DIR_LOW        16'h0300
`define OFS_DIR_HIGH       16'h0302
`define OFS_INEN_LOW       16'h0304
`define OFS_INEN_HIGH      16'h0306
`define OFS_PULL_LOW       16'h0308
`define OFS_PULL_HIGH      16'h030A
`define OFS_LEVEL_LOW      16'h030C
`define OFS_LEVEL_HIGH     16'h030E

// ==========================================================
// Field layout
`define PIN_COUNT          22
`define LOW_PINS           16
`define HIGH_PINS          6
`define ADDR_W             16
`define DATA_W             32

// ==========================================================
// Reset values
`define RST_DIR            22'h000000
`define RST_INEN           22'h000000
`define RST_PULL           22'h3FFFFF
`define RST_LEVEL          22'h000000
`define RST_PULL_LOW       16'hFFFF
`define RST_PULL_HIGH      16'h003F

// ==========================================================
// Timing: reads stall one cycle longer than writes; data is ready when the request is taken
`define READ_WAIT_CYCLES   1

`endif

// file: gpio_pkg.sv
// Types shared by the pin block
package gpio_pkg;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [15:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } bus_req_t;

  typedef struct packed {
    logic [21:0] level;
    logic [21:0] oe_n;
    logic [21:0] pull_en;
  } pin_drive_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_READ,
    BUS_DONE
  } bus_state_t;

endpackage

// file: pin_sampler.sv
// Registers the pin levels and masks those whose input function is off
`timescale 1ns/1ps
module pin_sampler
  import gpio_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [21:0] pin_in,
  input  wire logic [21:0] input_allowed,
  output logic      [21:0] sampled_q
);

  // ==========================================================
  // Sampling
  // Disabled inputs read low so a floating pad never reaches software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sampled_q <= 22'h000000;
    end else if (clk_en) begin
      sampled_q <= pin_in & input_allowed;
    end
  end

endmodule

// file: pin_driver.sv
// Registers the drive, enable and pull-down values presented to the pads
`timescale 1ns/1ps
module pin_driver
  import gpio_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire pin_drive_t  drive_d,
  output pin_drive_t       drive_q
);

  // ==========================================================
  // Pad registers
  // Reset leaves all pads undriven with pull-downs active
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drive_q <= '{level: 22'h000000, oe_n: 22'h3FFFFF, pull_en: 22'h3FFFFF};
    end else if (clk_en) begin
      drive_q <= drive_d;
    end
  end

endmodule

// file: board_pins.sv
// Board-side model of the 22 pads: external drivers, pull-downs and floating pins
`timescale 1ns/1ps
module board_pins (
  input  wire logic        clk_sys,
  input  wire logic [21:0] pin_out,
  input  wire logic [21:0] pin_oe_n,
  input  wire logic [21:0] pin_pulldown_en,
  input  wire logic [21:0] ext_level,
  input  wire logic [21:0] ext_en,
  output logic      [21:0] pin_in
);
  logic [21:0] float_q = 22'h155555;

  // ==========================================================
  // Pad resolution
  // An undriven pad with its pull-down off toggles every cycle, so a stale level never passes for a good read
  always @(posedge clk_sys) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 22; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_level[i];
      end else if (pin_pulldown_en[i]) begin
        pin_in[i] = 1'b0;
      end else begin
        pin_in[i] = float_q[i];
      end
    end
  end
endmodule

// file: gpio_pin_control_22_bench.sv
// Self-checking bench for the 22-pin port: register access, strap modes and pad levels
`timescale 1ns/1ps
`include "gpio_consts.svh"
module gpio_pin_control_22_bench;
  import gpio_pkg::*;

  logic        clk_sys;
  logic        rst_n;
  logic        clk_en;
  logic        direction_strap;
  logic [15:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [21:0] pin_in;
  logic [21:0] pin_out;
  logic [21:0] pin_oe_n;
  logic [21:0] pin_pulldown_en;
  logic [21:0] ext_level;
  logic [21:0] ext_en;
  int          fails;
  int          comparisons;

  gpio_pin_control_22 i_dut (
    .clk_sys         (clk_sys),
    .rst_n           (rst_n),
    .clk_en          (clk_en),
    .direction_strap (direction_strap),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .pin_in          (pin_in),
    .pin_out         (pin_out),
    .pin_oe_n        (pin_oe_n),
    .pin_pulldown_en (pin_pulldown_en)
  );

  board_pins i_board (
    .clk_sys         (clk_sys),
    .pin_out         (pin_out),
    .pin_oe_n        (pin_oe_n),
    .pin_pulldown_en (pin_pulldown_en),
    .ext_level       (ext_level),
    .ext_en          (ext_en),
    .pin_in          (pin_in)
  );

  // ==========================================================
  // Clock and closing
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic test_done;
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run is about 130 cycles; this leaves a wide margin
  initial begin
    repeat (4000) @(posedge clk_sys);
    fails++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    test_done;
  end

  // ==========================================================
  // Compares and bus tasks
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pins(input logic [21:0] got, input logic [21:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: pins %h expected %h", $time, got, exp);
    end
  endtask

  // A missing answer is caught by the watchdog
  task automatic wait_ack;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
  endtask

  task automatic bus_write(input logic [15:0] addr, input logic [15:0] data);
    avs_address   <= addr;
    avs_writedata <= {16'h0000, data};
    avs_write     <= 1'b1;
    wait_ack;
    avs_write     <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp);
    logic [31:0] got;
    avs_address <= addr;
    avs_read    <= 1'b1;
    wait_ack;
    got = avs_readdata;
    avs_read    <= 1'b0;
    @(posedge clk_sys);
    chk_reg(got, {16'h0000, exp});
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic do_reset(input logic strap);
    direction_strap <= strap;
    rst_n           <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n           <= 1'b1;
    idle(3);
  endtask

  // ==========================================================
  // Tests
  initial begin
    rst_n           = 1'b0;
    clk_en          = 1'b1;
    direction_strap = 1'b0;
    avs_address     = 16'h0000;
    avs_read        = 1'b0;
    avs_write       = 1'b0;
    avs_writedata   = 32'h00000000;
    avs_byteenable  = 4'h3;
    ext_level       = 22'h2B5A96;
    ext_en          = 22'h000000;
    fails           = 0;
    comparisons     = 0;
    @(posedge clk_sys);
    // Strap low: every pad is an output whatever the enables say
    do_reset(1'b0);
    chk_pins(pin_oe_n, 22'h000000);
    chk_pins(pin_pulldown_en, 22'h3FFFFF);
    rd_chk(`OFS_PULL_LOW, 16'hFFFF);
    rd_chk(`OFS_PULL_HIGH, 16'h003F);
    rd_chk(`OFS_LEVEL_LOW, 16'h0000);
    rd_chk(`OFS_LEVEL_HIGH, 16'h0000);
    bus_write(`OFS_LEVEL_LOW, 16'hA5C3);
    bus_write(`OFS_LEVEL_HIGH, 16'h002A);
    idle(2);
    chk_pins(pin_out, 22'h2AA5C3);
    rd_chk(`OFS_LEVEL_LOW, 16'hA5C3);
    rd_chk(`OFS_LEVEL_HIGH, 16'h002A);
    bus_write(`OFS_INEN_LOW, 16'hFFFF);
    idle(2);
    chk_pins(pin_oe_n, 22'h000000);
    bus_write(`OFS_PULL_LOW, 16'h1234);
    bus_write(`OFS_PULL_HIGH, 16'hFFD5);
    idle(2);
    chk_pins(pin_pulldown_en, 22'h151234);
    rd_chk(`OFS_PULL_LOW, 16'h1234);
    rd_chk(`OFS_PULL_HIGH, 16'h0015);
    // Upper byte lane only
    avs_byteenable <= 4'h2;
    bus_write(`OFS_PULL_LOW, 16'hABCD);
    avs_byteenable <= 4'h3;
    rd_chk(`OFS_PULL_LOW, 16'hAB34);
    // Unmapped place: write ignored, read zero
    bus_write(16'h0310, 16'hBEEF);
    rd_chk(16'h0310, 16'h0000);
    // Strap high: pads start as inputs, levels come from the board
    ext_en <= 22'h3FFFFF;
    do_reset(1'b1);
    chk_pins(pin_oe_n, 22'h3FFFFF);
    chk_pins(pin_out, 22'h000000);
    rd_chk(`OFS_LEVEL_LOW, 16'h0000);
    bus_write(`OFS_INEN_LOW, 16'hFFFF);
    bus_write(`OFS_INEN_HIGH, 16'h003F);
    idle(3);
    rd_chk(`OFS_LEVEL_LOW, 16'h5A96);
    rd_chk(`OFS_LEVEL_HIGH, 16'h002B);
    // Board lets go of pins 0-7 before they turn outputs, and of pin 21 so its pull-down reads low
    ext_en <= 22'h1FFF00;
    bus_write(`OFS_LEVEL_LOW, 16'h0033);
    bus_write(`OFS_DIR_LOW, 16'h00FF);
    idle(3);
    chk_pins(pin_oe_n, 22'h3FFF00);
    chk_pins(pin_out, 22'h000033);
    rd_chk(`OFS_LEVEL_LOW, 16'h5A33);
    rd_chk(`OFS_LEVEL_HIGH, 16'h000B);
    // Clock enable low: a held write waits and the pads stay put
    clk_en        <= 1'b0;
    avs_address   <= `OFS_LEVEL_LOW;
    avs_writedata <= 32'h000000C5;
    avs_write     <= 1'b1;
    idle(4);
    chk_pins(pin_out, 22'h000033);
    clk_en        <= 1'b1;
    wait_ack;
    avs_write     <= 1'b0;
    idle(3);
    chk_pins(pin_out, 22'h0000C5);
    rd_chk(`OFS_LEVEL_LOW, 16'h5AC5);
    test_done;
  end
endmodule
